// ==== rtl/rtc_alarm_pkg.sv ====
package rtc_alarm_pkg;

    // Register offsets on the 8-bit register port.
    localparam logic [7:0] OFF_CUR_MINUTE = 8'h01;
    localparam logic [7:0] OFF_CUR_HOUR = 8'h02;
    localparam logic [7:0] OFF_CUR_WEEKDAY = 8'h03;
    localparam logic [7:0] OFF_CUR_DATE = 8'h04;
    localparam logic [7:0] OFF_MINUTE_ALARM = 8'h08;
    localparam logic [7:0] OFF_HOUR_ALARM = 8'h09;
    localparam logic [7:0] OFF_WEEKDAY_ALARM = 8'h0A;
    localparam logic [7:0] OFF_EXT_CONTROL = 8'h0D;
    localparam logic [7:0] OFF_EVENT_FLAGS = 8'h0E;
    localparam logic [7:0] OFF_IRQ_CONTROL = 8'h0F;
    localparam logic [7:0] OFF_PIN_STATUS = 8'h10;

    // Field positions.
    localparam int EXCLUDE_BIT = 7;
    localparam int WDAY_SEL_BIT = 6;
    localparam int TICK_SEL_BIT = 5;
    localparam int TICK_FLAG_BIT = 5;
    localparam int ALARM_FLAG_BIT = 3;
    localparam int TICK_IE_BIT = 5;
    localparam int ALARM_IE_BIT = 3;
    localparam int SW_RESET_BIT = 0;

    // Read masks: bits outside a mask are fixed zero.
    localparam logic [7:0] MINUTE_MASK = 8'h7F;
    localparam logic [7:0] HOUR_MASK = 8'h3F;
    localparam logic [7:0] WEEKDAY_MASK = 8'h7F;
    localparam logic [7:0] DATE_MASK = 8'h3F;
    localparam logic [7:0] CTRL_MASK = 8'hFD;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Reset values of the writable registers.
    localparam logic [7:0] ALARM_RESET = 8'h00;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Time-update hold of the interrupt output.
    localparam real TICK_HOLD_MS = 7.1825;
    localparam real CLK_PERIOD_NS = 5.0;
    localparam int TICK_HOLD_CYCLES = $rtoi(TICK_HOLD_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int TICK_CNT_W = 21;

    // Running calendar from the timekeeping counters.
    typedef struct packed {
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] weekday;
        logic [7:0] date;
    } calendar_t;

    // One access on the register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        TICK_IDLE = 2'b01,
        TICK_HOLD = 2'b10
    } tick_state_t;

endpackage

// ==== rtl/rtc_alarm_irq.sv ====
`timescale 1ns/10ps

// Overview of operation
// RL1 - Tick event with tick interrupt disabled leaves the interrupt pin released.
// RL2 - Clearing the tick interrupt enable releases a tick-driven low at once.
// RL3 - Enabled tick event pulls the pin low, released automatically within 7.8 ms.
// RL4 - The pin is shared; one source disabled never blocks another active source.
// RL5 - Enabled alarm fields equal to the calendar set the alarm flag.
// RL6 - An alarm equal to present time fires only when counters advance into it.
// RL7 - Alarm flag stays set until software writes zero; writing one does nothing.
// RL8 - Enabled alarm holds the pin low until flag or enable is cleared.
// RL9 - Dropping the alarm enable releases the pin at once; re-enabling reasserts.
// RL10 - Clearing the alarm flag releases the pin at once.
// RL11 - Alarm with enable off still sets the flag but keeps the pin released.
// RL12 - While the software reset bit is set no alarm event occurs.
// RL13 - Select bit zero compares weekdays; one compares the date.
// RL14 - Weekday mode matches when the current weekday bit is set in the alarm.
// RL15 - Bit 7 of an alarm register removes it from the comparison.
// RL16 - All three exclude bits set gives an alarm every minute.
// RL17 - Alarm minute, hour and date are BCD compared with the time counters.
// RL18 - Bit 6 of hour and date alarm is plain storage, ignored by matching.
// RL19 - Fixed zero bits ignore writes and read zero.
// RL20 - Host keeps alarm enable zero when alarm registers serve as storage.
// RL21 - Host should clear alarm enable before changing alarm settings.
// RL22 - Tick flag sets on each second or minute update and holds until cleared.
module rtc_alarm_irq
    import rtc_alarm_pkg::*;
#(
    parameter int HOLD_CYCLES = TICK_HOLD_CYCLES
)
(
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port.
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Calendar and update pulses from the timekeeping counters.
    input wire calendar_t calendar,
    input wire logic second_tick,
    input wire logic minute_tick,
    // Software reset bit for the neighbouring counters.
    output logic sw_reset,
    // Open-drain interrupt pin.
    input wire logic irq_in,
    output logic irq_out,
    output logic irq_oe
);

    logic [7:0] minute_alarm;
    logic [7:0] hour_alarm;
    logic [7:0] weekday_alarm;
    logic [7:0] extension_control;
    logic [7:0] interrupt_control;
    logic tick_event_flag;
    logic alarm_flag;
    logic alarm_drive;
    calendar_t cal_q;
    tick_state_t tick_state;
    tick_state_t next_tick_state;
    logic [TICK_CNT_W-1:0] tick_count;
    logic [TICK_CNT_W-1:0] next_tick_count;
    logic pin_meta;
    logic pin_level;

    // Address decode of writes.
    wire wr_min_alarm = reg_req.wr && reg_req.addr == OFF_MINUTE_ALARM;
    wire wr_hour_alarm = reg_req.wr && reg_req.addr == OFF_HOUR_ALARM;
    wire wr_wday_alarm = reg_req.wr && reg_req.addr == OFF_WEEKDAY_ALARM;
    wire wr_ext = reg_req.wr && reg_req.addr == OFF_EXT_CONTROL;
    wire wr_flags = reg_req.wr && reg_req.addr == OFF_EVENT_FLAGS;
    wire wr_ctrl = reg_req.wr && reg_req.addr == OFF_IRQ_CONTROL;

    // Values after this cycle's write; the pin logic uses them so a clear acts at once.
    wire [7:0] next_ctrl = wr_ctrl ? (reg_req.wdata & CTRL_MASK) : interrupt_control; // RL19
    wire next_tick_ie = next_ctrl[TICK_IE_BIT];
    wire next_alarm_ie = next_ctrl[ALARM_IE_BIT];
    wire wday_select = extension_control[WDAY_SEL_BIT];
    wire tick_select = extension_control[TICK_SEL_BIT];
    assign sw_reset = interrupt_control[SW_RESET_BIT];

    // Update events follow the period select; the software reset holds them off.
    wire tick_event = (tick_select ? minute_tick : second_tick) && !sw_reset; // RL22

    // Flag clears: writing zero clears, writing one is ignored, and a set wins.
    wire clr_tick_flag = wr_flags && !reg_req.wdata[TICK_FLAG_BIT];
    wire clr_alarm_flag = wr_flags && !reg_req.wdata[ALARM_FLAG_BIT];
    wire next_tick_flag = tick_event || (tick_event_flag && !clr_tick_flag); // RL22

    // Field matches; an excluded field always agrees, bit 6 of hour and date is ignored.
    wire min_ok = minute_alarm[EXCLUDE_BIT] ||
        ((minute_alarm & MINUTE_MASK) == (calendar.minute & MINUTE_MASK)); // RL15 RL17
    wire hour_ok = hour_alarm[EXCLUDE_BIT] ||
        ((hour_alarm & HOUR_MASK) == (calendar.hour & HOUR_MASK)); // RL17 RL18
    wire date_hit = (weekday_alarm & DATE_MASK) == (calendar.date & DATE_MASK); // RL18
    wire wday_hit = |(weekday_alarm & calendar.weekday & WEEKDAY_MASK); // RL14
    wire day_ok = weekday_alarm[EXCLUDE_BIT] || (wday_select ? date_hit : wday_hit); // RL13 RL16
    wire alarm_match = min_ok && hour_ok && day_ok; // RL5

    // A match counts only on the cycle the calendar moves into it, so an alarm
    // written equal to the present time waits for its next occurrence.
    wire cal_moved = calendar != cal_q; // RL6
    wire alarm_event = alarm_match && cal_moved && !sw_reset; // RL5 RL12
    wire next_alarm_flag = alarm_event || (alarm_flag && !clr_alarm_flag); // RL7
    wire next_alarm_drive = next_alarm_flag && next_alarm_ie; // RL8 RL9 RL10 RL11

    // Pin drive: the output is a fixed low, the enable is the OR of both sources.
    assign irq_out = 1'b0;
    assign irq_oe = alarm_drive || tick_state == TICK_HOLD; // RL4

    // Tick hold sequencer: low for a fixed hold after each enabled update event.
    always_comb
    begin
        next_tick_state = tick_state;
        next_tick_count = tick_count;
        unique case (tick_state)
            TICK_IDLE:
            begin
                if (tick_event && next_tick_ie) // RL1
                begin
                    next_tick_state = TICK_HOLD;
                    next_tick_count = '0;
                end
            end
            TICK_HOLD:
            begin
                if (!next_tick_ie) // RL2
                begin
                    next_tick_state = TICK_IDLE;
                end
                else if (tick_event)
                begin
                    next_tick_count = '0;
                end
                else if (tick_count == TICK_CNT_W'(HOLD_CYCLES - 1)) // RL3
                begin
                    next_tick_state = TICK_IDLE;
                end
                else
                begin
                    next_tick_count = tick_count + 1'b1;
                end
            end
            default:
            begin
                next_tick_state = TICK_IDLE;
            end
        endcase
    end

    // Read selection; fixed-zero bits are masked off.
    logic [7:0] rd_value;
    always_comb
    begin
        unique case (reg_req.addr)
            OFF_CUR_MINUTE: rd_value = calendar.minute & MINUTE_MASK; // RL19
            OFF_CUR_HOUR: rd_value = calendar.hour & HOUR_MASK;
            OFF_CUR_WEEKDAY: rd_value = calendar.weekday & WEEKDAY_MASK;
            OFF_CUR_DATE: rd_value = calendar.date & DATE_MASK;
            OFF_MINUTE_ALARM: rd_value = minute_alarm;
            OFF_HOUR_ALARM: rd_value = hour_alarm;
            OFF_WEEKDAY_ALARM: rd_value = weekday_alarm;
            OFF_EXT_CONTROL: rd_value = extension_control;
            OFF_EVENT_FLAGS:
            begin
                rd_value = BYTE_ZERO;
                rd_value[TICK_FLAG_BIT] = tick_event_flag;
                rd_value[ALARM_FLAG_BIT] = alarm_flag;
            end
            OFF_IRQ_CONTROL: rd_value = interrupt_control;
            OFF_PIN_STATUS: rd_value = {7'h00, pin_level};
            default: rd_value = BYTE_ZERO;
        endcase
    end

    // Register file; the calendar rows are read-only views of the counters.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            minute_alarm <= ALARM_RESET;
            hour_alarm <= ALARM_RESET;
            weekday_alarm <= ALARM_RESET;
            extension_control <= EXT_RESET;
            interrupt_control <= CTRL_RESET;
        end
        else if (clk_en)
        begin
            if (wr_min_alarm) minute_alarm <= reg_req.wdata;
            if (wr_hour_alarm) hour_alarm <= reg_req.wdata; // RL18
            if (wr_wday_alarm) weekday_alarm <= reg_req.wdata;
            if (wr_ext) extension_control <= reg_req.wdata;
            interrupt_control <= next_ctrl;
        end
    end

    // Flags, pin state and the calendar snapshot used to see it move.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_event_flag <= 1'b0;
            alarm_flag <= 1'b0;
            alarm_drive <= 1'b0;
            tick_state <= TICK_IDLE;
            tick_count <= '0;
            cal_q <= '0;
        end
        else if (clk_en)
        begin
            tick_event_flag <= next_tick_flag;
            alarm_flag <= next_alarm_flag;
            alarm_drive <= next_alarm_drive;
            tick_state <= next_tick_state;
            tick_count <= next_tick_count;
            cal_q <= calendar;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= BYTE_ZERO;
        end
        else if (clk_en)
        begin
            reg_rdata <= reg_req.rd ? rd_value : BYTE_ZERO;
        end
    end

    // The pin level comes from outside the clock domain, so it is synchronised.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_meta <= 1'b1;
            pin_level <= 1'b1;
        end
        else if (clk_en)
        begin
            pin_meta <= irq_in;
            pin_level <= pin_meta;
        end
    end

    // Checks next to the logic they guard.
    a_tick_disabled_quiet: assert property ( // RL1
        @(posedge clk) disable iff (!rst_n)
        clk_en && tick_event && !next_tick_ie && tick_state == TICK_IDLE
        |=> tick_state == TICK_IDLE)
        else $error("tick event drove pin with enable off");

    a_tick_enable_release: assert property ( // RL2
        @(posedge clk) disable iff (!rst_n)
        clk_en && wr_ctrl && !reg_req.wdata[TICK_IE_BIT] && !next_alarm_drive |=> !irq_oe)
        else $error("pin not released after tick enable cleared");

    a_tick_hold_bound: assert property ( // RL3
        @(posedge clk) disable iff (!rst_n)
        tick_state == TICK_HOLD |-> tick_count < TICK_CNT_W'(HOLD_CYCLES))
        else $error("tick hold exceeded its limit");

    a_tick_starts_low: assert property ( // RL3
        @(posedge clk) disable iff (!rst_n)
        clk_en && tick_event && next_tick_ie |=> irq_oe && !irq_out)
        else $error("enabled tick event did not pull pin low");

    a_shared_pin_drive: assert property ( // RL4
        @(posedge clk) disable iff (!rst_n)
        alarm_drive || tick_state == TICK_HOLD |-> irq_oe && !irq_out)
        else $error("active source not driving pin");

    a_alarm_sets_flag: assert property ( // RL5
        @(posedge clk) disable iff (!rst_n)
        clk_en && alarm_event |=> alarm_flag)
        else $error("alarm event did not set flag");

    a_alarm_needs_advance: assert property ( // RL6
        @(posedge clk) disable iff (!rst_n)
        calendar == cal_q |-> !alarm_event)
        else $error("alarm fired without calendar advance");

    a_alarm_flag_sticky: assert property ( // RL7
        @(posedge clk) disable iff (!rst_n)
        alarm_flag && !(clk_en && clr_alarm_flag) |=> alarm_flag)
        else $error("alarm flag dropped without a zero write");

    a_alarm_drive_follows: assert property ( // RL8
        @(posedge clk) disable iff (!rst_n)
        alarm_drive == (alarm_flag && interrupt_control[ALARM_IE_BIT]))
        else $error("alarm drive differs from flag and enable");

    a_alarm_clear_release: assert property ( // RL10
        @(posedge clk) disable iff (!rst_n)
        clk_en && clr_alarm_flag && !alarm_event && tick_state == TICK_IDLE
        && next_tick_state == TICK_IDLE |=> !irq_oe)
        else $error("pin not released after alarm flag cleared");

    a_soft_reset_mute: assert property ( // RL12
        @(posedge clk) disable iff (!rst_n)
        sw_reset |-> !alarm_event)
        else $error("alarm event during software reset");

    a_weekday_mode_match: assert property ( // RL14
        @(posedge clk) disable iff (!rst_n)
        !wday_select && !weekday_alarm[EXCLUDE_BIT]
        |-> day_ok == |(weekday_alarm[6:0] & calendar.weekday[6:0]))
        else $error("weekday comparison wrong");

    a_date_mode_match: assert property ( // RL13
        @(posedge clk) disable iff (!rst_n)
        wday_select && !weekday_alarm[EXCLUDE_BIT]
        |-> day_ok == (weekday_alarm[5:0] == calendar.date[5:0]))
        else $error("date comparison wrong");

    a_alarm_ie_release: assert property ( // RL9
        @(posedge clk) disable iff (!rst_n)
        clk_en && wr_ctrl && !reg_req.wdata[ALARM_IE_BIT]
        |=> !alarm_drive)
        else $error("alarm drive kept after enable cleared");

    a_alarm_off_quiet: assert property ( // RL11
        @(posedge clk) disable iff (!rst_n)
        clk_en && alarm_event && !next_alarm_ie
        |=> alarm_flag && !alarm_drive)
        else $error("disabled alarm drove the pin or lost its flag");

    a_all_exclude_minute: assert property ( // RL16
        @(posedge clk) disable iff (!rst_n)
        minute_alarm[EXCLUDE_BIT] && hour_alarm[EXCLUDE_BIT] && weekday_alarm[EXCLUDE_BIT]
        && cal_moved && !sw_reset |-> alarm_event)
        else $error("fully excluded alarm missed a calendar step");

    a_tick_flag_sticky: assert property ( // RL22
        @(posedge clk) disable iff (!rst_n)
        (clk_en && tick_event) || (tick_event_flag && !(clk_en && clr_tick_flag))
        |=> tick_event_flag)
        else $error("tick flag not set or dropped without a zero write");

    a_ctrl_fixed_zero: assert property ( // RL19
        @(posedge clk) disable iff (!rst_n)
        (interrupt_control & ~CTRL_MASK) == BYTE_ZERO)
        else $error("fixed zero control bit was stored");

endmodule // rtc_alarm_irq

// ==== tb/time_source_model.sv ====
`timescale 1ns/10ps

// Stand-in for the timekeeping counters and the board around the shared pin.
module time_source_model
    import rtc_alarm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the bench.
    input wire calendar_t cal_set,
    input wire logic sec_req,
    input wire logic min_req,
    // Block side.
    output calendar_t calendar,
    output logic second_tick,
    output logic minute_tick,
    input wire logic irq_out,
    input wire logic irq_oe,
    output logic pin
);
    // The pull-up holds the pin high whenever no source drives it.
    assign pin = irq_oe ? irq_out : 1'b1;

    // Counters only move on clock edges, so the calendar is never seen half-updated.
    always_ff @(posedge clk)
    begin
        calendar <= cal_set;
        second_tick <= sec_req & rst_n;
        minute_tick <= min_req & rst_n;
    end
endmodule // time_source_model

// ==== tb/test_rtc_alarm_irq.sv ====
`timescale 1ns/10ps

module test_rtc_alarm_irq;
    import rtc_alarm_pkg::*;
    localparam int HOLD = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req = '0;
    calendar_t cal_set = '0;
    calendar_t calendar;
    logic sec_req = 1'b0;
    logic min_req = 1'b0;
    logic en = 1'b1;
    logic [7:0] rdata;
    logic second_tick, minute_tick, sw_reset, irq_out, irq_oe, pin;
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    logic [7:0] offs [6] = '{8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E, 8'h0F};
    // Match table: minute, hour and shared alarm, select bit, calendar, expected flag.
    logic [7:0] tm [8] = '{8'h30, 8'h30, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h59};
    logic [7:0] th [8] = '{8'h07, 8'h07, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h18};
    logic [7:0] tk [8] = '{8'h80, 8'h80, 8'h05, 8'h05, 8'h55, 8'h15, 8'h80, 8'h80};
    logic tw [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic te [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    calendar_t tc [8] = '{32'h3007_0101, 32'h3107_0101, 32'h0000_0401, 32'h0000_0215,
                          32'h0000_0215, 32'h0000_0416, 32'h1101_0000, 32'h5908_0101};

    // Half-period toggle gives the 200 MHz clock.
    always #2.5 clk = ~clk;

    rtc_alarm_irq #(.HOLD_CYCLES(HOLD)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(en),
        .reg_req(req), .reg_rdata(rdata), .calendar(calendar), .second_tick(second_tick),
        .minute_tick(minute_tick), .sw_reset(sw_reset), .irq_in(pin), .irq_out(irq_out),
        .irq_oe(irq_oe));

    time_source_model far (.clk(clk), .rst_n(rst_n), .cal_set(cal_set), .sec_req(sec_req),
        .min_req(min_req), .calendar(calendar), .second_tick(second_tick),
        .minute_tick(minute_tick), .irq_out(irq_out), .irq_oe(irq_oe), .pin(pin));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic chk_pin(input logic e);
        chk({7'h00, pin}, {7'h00, e});
    endtask

    // A new calendar value needs a few cycles before flags can be read.
    task automatic step(input calendar_t c);
        @(posedge clk);
        cal_set <= c;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input logic m);
        @(posedge clk);
        if (m)
            min_req <= 1'b1;
        else
            sec_req <= 1'b1;
        @(posedge clk);
        min_req <= 1'b0;
        sec_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The whole run is a few hundred cycles; a hang is cut off well beyond that.
    initial
    begin
        #60000;
        error_cnt++;
        results();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (offs[i]) chk_rd(offs[i], 8'h00);
        chk_rd(OFF_PIN_STATUS, 8'h01);
        wr(OFF_HOUR_ALARM, 8'hFF);
        chk_rd(OFF_HOUR_ALARM, 8'hFF);
        wr(OFF_EVENT_FLAGS, 8'hFF);
        chk_rd(OFF_EVENT_FLAGS, 8'h00);
        step(32'hD9E3_81C5);
        wr(OFF_CUR_MINUTE, 8'h00);
        chk_rd(OFF_CUR_MINUTE, 8'h59);
        chk_rd(OFF_CUR_HOUR, 8'h23);
        chk_rd(OFF_CUR_WEEKDAY, 8'h01);
        chk_rd(OFF_CUR_DATE, 8'h05);
        chk_rd(8'h20, 8'h00);
        wr(OFF_IRQ_CONTROL, 8'hFF);
        chk_rd(OFF_IRQ_CONTROL, 8'hFD);
        wr(OFF_IRQ_CONTROL, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            wr(OFF_EXT_CONTROL, {1'b0, tw[i], 6'h00});
            wr(OFF_MINUTE_ALARM, tm[i]);
            wr(OFF_HOUR_ALARM, th[i]);
            wr(OFF_WEEKDAY_ALARM, tk[i]);
            step('0);
            wr(OFF_EVENT_FLAGS, 8'h00);
            step(tc[i]);
            chk_rd(OFF_EVENT_FLAGS, te[i] ? 8'h08 : 8'h00);
            chk_pin(1'b1);
        end
        $display("test matching done");
        wr(OFF_HOUR_ALARM, 8'h08);
        wr(OFF_EVENT_FLAGS, 8'h00);
        repeat (5) @(posedge clk);
        chk_rd(OFF_EVENT_FLAGS, 8'h00);
        wr(OFF_IRQ_CONTROL, 8'h08);
        step('0);
        step(tc[7]);
        chk_pin(1'b0);
        wr(OFF_EVENT_FLAGS, 8'h08);
        repeat (HOLD + 10) @(posedge clk);
        #1;
        chk_pin(1'b0);
        chk_rd(OFF_PIN_STATUS, 8'h00);
        chk_rd(OFF_EVENT_FLAGS, 8'h08);
        wr(OFF_IRQ_CONTROL, 8'h28);
        pulse(1'b0);
        wr(OFF_IRQ_CONTROL, 8'h08);
        @(posedge clk);
        #1;
        chk_pin(1'b0);
        wr(OFF_IRQ_CONTROL, 8'h00);
        @(posedge clk);
        #1;
        chk_pin(1'b1);
        wr(OFF_IRQ_CONTROL, 8'h08);
        chk_pin(1'b0);
        wr(OFF_EVENT_FLAGS, 8'h00);
        step('0);
        step(tc[7]);
        chk_pin(1'b0);
        wr(OFF_EVENT_FLAGS, 8'h00);
        @(posedge clk);
        #1;
        chk_pin(1'b1);
        wr(OFF_IRQ_CONTROL, 8'h01);
        chk({7'h00, sw_reset}, 8'h01);
        step('0);
        step(tc[7]);
        chk_rd(OFF_EVENT_FLAGS, 8'h00);
        chk_pin(1'b1);
        wr(OFF_IRQ_CONTROL, 8'h00);
        $display("test alarm pin done");
        pulse(1'b0);
        chk_rd(OFF_EVENT_FLAGS, 8'h20);
        chk_pin(1'b1);
        wr(OFF_IRQ_CONTROL, 8'h20);
        @(posedge clk);
        sec_req <= 1'b1;
        @(posedge clk);
        sec_req <= 1'b0;
        n = 0;
        repeat (HOLD + 20)
        begin
            @(posedge clk);
            #1;
            if (pin === 1'b0)
                n++;
        end
        chk(n[7:0], 8'(HOLD));
        pulse(1'b0);
        chk_pin(1'b0);
        wr(OFF_IRQ_CONTROL, 8'h00);
        @(posedge clk);
        #1;
        chk_pin(1'b1);
        wr(OFF_EXT_CONTROL, 8'h20);
        wr(OFF_EVENT_FLAGS, 8'h00);
        pulse(1'b0);
        chk_rd(OFF_EVENT_FLAGS, 8'h00);
        pulse(1'b1);
        chk_rd(OFF_EVENT_FLAGS, 8'h20);
        // A write while the clock enable is low must not land.
        @(posedge clk);
        en <= 1'b0;
        wr(OFF_MINUTE_ALARM, 8'h11);
        @(posedge clk);
        en <= 1'b1;
        chk_rd(OFF_MINUTE_ALARM, 8'h59);
        $display("test tick done");
        results();
    end
endmodule // test_rtc_alarm_irq
